// [core/ppc_regs.sv]
// per-port control, status and discovery result registers for four ports
// ==========================================
// What this block does
// - control two: D4 disables port, D3 self-clearing start, D2 abort
// - function done set on completion, cleared by new function write; D7 discovery fail
// - three-bit fault field: none, supply, thermal, overload, disconnect; rest reserved
// - status two D3 reads one while a conversion runs
// - 15-bit discovery result split into low byte and high D0..D6
// - measurement-complete flag clears when either discovery starts
// - measurement-complete flag sets when any conversion finishes
// - function codes 0001 and 0010 select the two discovery operations
module ppc_regs
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [1:0] port_sel,
	input wire logic [3:0] reg_sel,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic [3:0] func_done_evt,
	input wire logic [3:0] disc_fail_evt,
	input wire logic [11:0] port_class,
	input wire logic [11:0] fault_code,
	input wire logic [3:0] wdog_active,
	input wire logic [11:0] func_state,
	input wire logic [59:0] adc_sample,
	output logic [3:0] port_disable,
	output logic [3:0] conv_active,
	output logic [15:0] func_code
);
	import ppc_pkg::*;

	logic [3:0] dis_reg;
	logic [3:0] abort_reg;
	logic [3:0] done_reg;
	logic [3:0] fail_reg;
	logic [3:0] start_w;
	logic [3:0] func_w;
	logic [3:0] disc_begin;
	logic [3:0] meas_done;
	logic [59:0] result;
	logic [3:0] ctrl_two_w;
	logic [2:0] sel_class;
	logic [2:0] sel_fault;
	logic [2:0] sel_state;
	logic [14:0] sel_result;
	logic [7:0] rd_next;

	// ==========================================
	// decode and byte assembly
	// decode of a write to one port's register
	function automatic logic hit(input logic [1:0] p, input logic [3:0] s, input int i,
			input logic [3:0] want);
		hit = (p == i[1:0]) && (s == want);
	endfunction

	// reserved fault codes are masked to none so software never reads one
	function automatic logic [2:0] fault_map(input logic [2:0] f);
		case (f)
			PPC_FAULT_SUPPLY_WINDOW: fault_map = f;
			PPC_FAULT_THERMAL_SHUTDOWN: fault_map = f;
			PPC_FAULT_OVERLOAD: fault_map = f;
			PPC_FAULT_DISCONNECT: fault_map = f;
			default: fault_map = PPC_FAULT_NONE;
		endcase
	endfunction

	// status one from msb down: fail, done, class, fault
	function automatic logic [7:0] status_one_byte(input logic fail, input logic done,
			input logic [2:0] cls, input logic [2:0] fault);
		status_one_byte = PPC_RESET_BYTE;
		status_one_byte[PPC_BIT_DISC_FAIL] = fail;
		status_one_byte[PPC_BIT_FUNC_DONE] = done;
		status_one_byte[5:3] = cls;
		status_one_byte[2:0] = fault;
	endfunction

	// status two: upper three bits always read zero
	function automatic logic [7:0] status_two_byte(input logic wdog, input logic act,
			input logic [2:0] state);
		status_two_byte = PPC_RESET_BYTE;
		status_two_byte[PPC_BIT_WDOG] = wdog;
		status_two_byte[PPC_BIT_CONV_ACT] = act;
		status_two_byte[2:0] = state;
	endfunction

	// completion flag sits above the seven upper result bits
	function automatic logic [7:0] disc_high_byte(input logic meas, input logic [6:0] hi);
		disc_high_byte = PPC_RESET_BYTE;
		disc_high_byte[PPC_BIT_MEAS_DONE] = meas;
		disc_high_byte[6:0] = hi;
	endfunction

	// ==========================================
	// per-port logic
	genvar g;
	for (g = 0; g < PPC_NUM_PORTS; g++) begin : g_port
		assign func_w[g] = clk_en && wr_en && hit(port_sel, reg_sel, g, PPC_SEL_CTRL_ONE);
		assign ctrl_two_w[g] = clk_en && wr_en && hit(port_sel, reg_sel, g, PPC_SEL_CTRL_TWO);
		// start is a strobe only, so it never reads back as set
		assign start_w[g] = ctrl_two_w[g] && wr_data[PPC_BIT_START];
		// only the two discovery codes restart the result flag
		assign disc_begin[g] = func_w[g] && ((wr_data[3:0] == PPC_FUNC_DISC1)
			|| (wr_data[3:0] == PPC_FUNC_DISC2));

		// disable and abort are plain levels held from control two
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				dis_reg[g] <= 1'b0;
			end else if (ctrl_two_w[g]) begin
				dis_reg[g] <= wr_data[PPC_BIT_PORT_DIS];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				abort_reg[g] <= 1'b0;
			end else if (ctrl_two_w[g]) begin
				abort_reg[g] <= wr_data[PPC_BIT_ABORT];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				func_code[g*4 +: 4] <= 4'h0;
			end else if (func_w[g]) begin
				func_code[g*4 +: 4] <= wr_data[3:0];
			end
		end

		// set wins over the clear of a same-cycle function write
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				done_reg[g] <= 1'b0;
			end else if (clk_en) begin
				if (func_done_evt[g]) begin
					done_reg[g] <= 1'b1;
				end else if (func_w[g]) begin
					done_reg[g] <= 1'b0;
				end
			end
		end

		// a new discovery clears the fail bit, a same-cycle fail still wins
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				fail_reg[g] <= 1'b0;
			end else if (clk_en) begin
				if (disc_fail_evt[g]) begin
					fail_reg[g] <= 1'b1;
				end else if (disc_begin[g]) begin
					fail_reg[g] <= 1'b0;
				end
			end
		end

		// one sequencer per port; its done strobe stays inside it
		ppc_conv u_conv (
			.ref_clk(ref_clk),
			.rst(rst),
			.clk_en(clk_en),
			.start(start_w[g]),
			.abort(abort_reg[g]),
			.disc_begin(disc_begin[g]),
			.sample(adc_sample[g*15 +: 15]),
			.busy(conv_active[g]),
			.done_pulse(),
			.meas_done(meas_done[g]),
			.result(result[g*15 +: 15])
		);
	end

	// the disable level goes straight out to the port switch
	assign port_disable = dis_reg;

	// ==========================================
	// fields of the port being read
	assign sel_class = port_class[port_sel*3 +: 3];
	assign sel_fault = fault_code[port_sel*3 +: 3];
	assign sel_state = func_state[port_sel*3 +: 3];
	assign sel_result = result[port_sel*15 +: 15];

	// ==========================================
	// read path; write-only and unmapped selects read zero
	always_comb begin
		rd_next = PPC_RESET_BYTE;
		case (reg_sel)
			PPC_SEL_STATUS_ONE: begin
				rd_next = status_one_byte(fail_reg[port_sel], done_reg[port_sel], sel_class,
					fault_map(sel_fault));
			end
			PPC_SEL_STATUS_TWO: begin
				rd_next = status_two_byte(wdog_active[port_sel], conv_active[port_sel],
					sel_state);
			end
			PPC_SEL_DISC_LOW: begin
				rd_next = sel_result[7:0];
			end
			PPC_SEL_DISC_HIGH: begin
				rd_next = disc_high_byte(meas_done[port_sel], sel_result[14:8]);
			end
			default: begin
				rd_next = PPC_RESET_BYTE;
			end
		endcase
	end

	// registered so the byte holds steady until the next read strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= PPC_RESET_BYTE;
		end else if (clk_en && rd_en) begin
			rd_data <= rd_next;
		end
	end
endmodule

// [common/ppc_pkg.sv]
// shared constants for the per-port control and status register group
package ppc_pkg;
	// ==========================================
	// register selects
	localparam logic [3:0] PPC_SEL_CTRL_ONE = 4'h2;
	localparam logic [3:0] PPC_SEL_CTRL_TWO = 4'h3;
	localparam logic [3:0] PPC_SEL_STATUS_ONE = 4'h4;
	localparam logic [3:0] PPC_SEL_STATUS_TWO = 4'h5;
	localparam logic [3:0] PPC_SEL_DISC_LOW = 4'h6;
	localparam logic [3:0] PPC_SEL_DISC_HIGH = 4'h7;
	// ==========================================
	// field positions
	localparam int PPC_BIT_PORT_DIS = 4;
	localparam int PPC_BIT_START = 3;
	localparam int PPC_BIT_ABORT = 2;
	localparam int PPC_BIT_DISC_FAIL = 7;
	localparam int PPC_BIT_FUNC_DONE = 6;
	localparam int PPC_BIT_WDOG = 4;
	localparam int PPC_BIT_CONV_ACT = 3;
	localparam int PPC_BIT_MEAS_DONE = 7;
	// ==========================================
	// reset values and codes
	localparam logic [7:0] PPC_RESET_BYTE = 8'h00;
	localparam logic [3:0] PPC_FUNC_DISC1 = 4'h1;
	localparam logic [3:0] PPC_FUNC_DISC2 = 4'h2;
	localparam logic [2:0] PPC_FAULT_NONE = 3'h0;
	localparam logic [2:0] PPC_FAULT_SUPPLY_WINDOW = 3'h1;
	localparam logic [2:0] PPC_FAULT_THERMAL_SHUTDOWN = 3'h2;
	localparam logic [2:0] PPC_FAULT_OVERLOAD = 3'h3;
	localparam logic [2:0] PPC_FAULT_DISCONNECT = 3'h4;
	localparam int PPC_NUM_PORTS = 4;
	// conversion length in cycles
	localparam logic [7:0] PPC_CONV_CYCLES = 8'h20;
	typedef enum logic [1:0] {PPC_IDLE, PPC_CONV} ppc_state_e;
endpackage

// [core/ppc_conv.sv]
// one port's conversion sequencer and result holder
module ppc_conv
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic start,
	input wire logic abort,
	input wire logic disc_begin,
	input wire logic [14:0] sample,
	output logic busy,
	output logic done_pulse,
	output logic meas_done,
	output logic [14:0] result
);
	ppc_state_e state_reg;
	logic [7:0] cnt_reg;

	assign busy = (state_reg == PPC_CONV);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= PPC_IDLE;
			cnt_reg <= 8'h00;
			done_pulse <= 1'b0;
		end else if (clk_en) begin
			done_pulse <= 1'b0;
			case (state_reg)
				PPC_IDLE: begin
					if (start && !abort) begin
						state_reg <= PPC_CONV;
						cnt_reg <= 8'h00;
					end
				end
				PPC_CONV: begin
					if (abort) begin
						state_reg <= PPC_IDLE;
					end else if (cnt_reg == PPC_CONV_CYCLES - 8'h01) begin
						state_reg <= PPC_IDLE;
						done_pulse <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg + 8'h01;
					end
				end
				default: state_reg <= PPC_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result <= 15'h0000;
		end else if (clk_en && done_pulse) begin
			result <= sample;
		end
	end

	// flag sets on any conversion done and clears only on a new discovery; that clear beats a late done
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meas_done <= 1'b0;
		end else if (clk_en) begin
			if (disc_begin) begin
				meas_done <= 1'b0;
			end else if (done_pulse) begin
				meas_done <= 1'b1;
			end
		end
	end
endmodule

// [testbench/ppc_regs_props.sv]
// assertion checker for the per-port register group
module ppc_regs_props
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [1:0] port_sel,
	input wire logic [3:0] reg_sel,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic [3:0] port_disable,
	input wire logic [3:0] conv_active,
	input wire logic [15:0] func_code
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// strobe to register relations
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || !clk_en);
	wire w1 = wr_en && reg_sel == PPC_SEL_CTRL_ONE;
	wire w2 = wr_en && reg_sel == PPC_SEL_CTRL_TWO;
	// an abort on port 0 legally cuts the count short
	wire ab0 = !clk_en || (w2 && port_sel == 2'h0 && wr_data[2]);
	// mirrors the abort level, since a start under a standing abort is ignored
	logic [3:0] abort_lvl;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			abort_lvl <= 4'h0;
		end else if (clk_en && w2) begin
			abort_lvl[port_sel] <= wr_data[2];
		end
	end
	a_start_taken: assert property
		(w2 && wr_data[3:2] == 2'h2 && !abort_lvl[port_sel] |=> conv_active[$past(port_sel)])
		else $error("start lost");
	a_conv_length: assert property (disable iff (rst || ab0)
		$rose(conv_active[0]) |-> ##31 conv_active[0] ##1 !conv_active[0]) else $error("bad length");
	a_abort_stops: assert property
		(w2 && wr_data[2] |=> ##1 !conv_active[$past(port_sel, 2)]) else $error("abort ignored");
	a_disable_bit: assert property
		(w2 |=> port_disable[$past(port_sel)] == $past(wr_data[4])) else $error("bad disable");
	a_active_read: assert property
		(rd_en && reg_sel == PPC_SEL_STATUS_TWO |=> rd_data[3] == $past(conv_active[port_sel]))
		else $error("bad active bit");
	a_unmapped_zero: assert property
		(rd_en && !(reg_sel inside {[4'h4:4'h7]}) |=> rd_data == 8'h00) else $error("not zero");
	a_func_code: assert property
		(w1 |=> func_code[4*$past(port_sel) +: 4] == $past(wr_data[3:0])) else $error("bad code");
	a_read_holds: assert property
		(!rd_en |=> $stable(rd_data)) else $error("read byte moved");
endmodule

bind ppc_regs ppc_regs_props i_ppc_regs_props(.ref_clk, .rst, .clk_en, .port_sel, .reg_sel,
	.wr_en, .wr_data, .rd_en, .rd_data, .port_disable, .conv_active, .func_code);

// [testbench/ppc_host.sv]
// host model: one register access at a time on the strobe bus
module ppc_host
(
	input wire logic ref_clk,
	input wire logic [7:0] rd_data,
	output logic clk_en,
	output logic [1:0] port_sel,
	output logic [3:0] reg_sel,
	output logic wr_en,
	output logic [7:0] wr_data,
	output logic rd_en
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// access tasks
	initial begin
		clk_en = 1'b1;
		{port_sel, reg_sel, wr_en, wr_data, rd_en} = '0;
	end
	task automatic wr(input logic [1:0] p, input logic [3:0] s, input logic [7:0] d);
		@(negedge ref_clk);
		{port_sel, reg_sel, wr_data, wr_en} = {p, s, d, 1'b1};
		@(negedge ref_clk);
		// idle data inverted so a stale byte cannot pass
		{wr_en, wr_data} = {1'b0, ~d};
	endtask
	task automatic rd(input logic [1:0] p, input logic [3:0] s, output logic [7:0] d);
		@(negedge ref_clk);
		{port_sel, reg_sel, rd_en} = {p, s, 1'b1};
		@(negedge ref_clk);
		rd_en = 1'b0;
		d = rd_data;
	endtask
	// freezes the block for n edges through the clock enable
	task automatic hold(input int n);
		@(negedge ref_clk);
		clk_en = 1'b0;
		repeat (n) @(negedge ref_clk);
		clk_en = 1'b1;
	endtask
endmodule

// [testbench/poe_port_ctrl_status_regs_test.sv]
// self-checking bench for the per-port register group
module poe_port_ctrl_status_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ppc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en, wr_en, rd_en;
	logic [1:0] port_sel;
	logic [3:0] reg_sel, port_disable, conv_active;
	logic [7:0] wr_data, rd_data, v;
	logic [3:0] func_done_evt = '0, disc_fail_evt = '0, wdog_active = '0;
	logic [11:0] port_class = '0, fault_code = '0, func_state = '0;
	logic [59:0] adc_sample = '0;
	logic [15:0] func_code;
	logic [14:0] r;
	int bad_count, num_checks;
	ppc_regs i_ppc_regs(.ref_clk, .rst, .clk_en, .port_sel, .reg_sel, .wr_en, .wr_data, .rd_en,
		.rd_data, .func_done_evt, .disc_fail_evt, .port_class, .fault_code, .wdog_active,
		.func_state, .adc_sample, .port_disable, .conv_active, .func_code);
	ppc_host i_ppc_host(.ref_clk, .rd_data, .clk_en, .port_sel, .reg_sel, .wr_en, .wr_data, .rd_en);
	initial forever #12.5 ref_clk = ~ref_clk;
	// ====
	// checking and scenarios
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(logic [1:0] p, logic [3:0] s, logic [7:0] e);
		i_ppc_host.rd(p, s, v);
		chk($sformatf("port %0d sel %h", p, s), v, e);
	endtask
	task automatic t_disc;
		for (int c = 1; c < 3; c++) begin
			r = adc_sample[14:0];
			adc_sample[14:0] = 15'h5A3C ^ 15'(c);
			i_ppc_host.wr(2'h0, PPC_SEL_CTRL_ONE, 8'(c));
			chk("function code", {4'h0, func_code[3:0]}, 8'(c));
			rchk(2'h0, PPC_SEL_DISC_HIGH, {1'b0, r[14:8]});
			i_ppc_host.wr(2'h0, PPC_SEL_CTRL_TWO, 8'h08);
			rchk(2'h0, PPC_SEL_STATUS_TWO, 8'h08);
			repeat (34) @(negedge ref_clk);
			rchk(2'h0, PPC_SEL_DISC_LOW, adc_sample[7:0]);
			rchk(2'h0, PPC_SEL_DISC_HIGH, {1'b1, adc_sample[14:8]});
			rchk(2'h0, PPC_SEL_STATUS_TWO, 8'h00);
		end
	endtask
	task automatic t_abort;
		i_ppc_host.wr(2'h1, PPC_SEL_CTRL_ONE, 8'h01);
		i_ppc_host.wr(2'h1, PPC_SEL_CTRL_TWO, 8'h08);
		i_ppc_host.wr(2'h1, PPC_SEL_CTRL_TWO, 8'h04);
		rchk(2'h1, PPC_SEL_STATUS_TWO, 8'h00);
		i_ppc_host.wr(2'h1, PPC_SEL_CTRL_TWO, 8'h0C);
		repeat (40) @(negedge ref_clk);
		rchk(2'h1, PPC_SEL_DISC_HIGH, 8'h00);
		i_ppc_host.wr(2'h1, PPC_SEL_CTRL_TWO, 8'h10);
		chk("port disable", {4'h0, port_disable}, 8'h02);
		i_ppc_host.wr(2'h1, PPC_SEL_CTRL_TWO, 8'h00);
		chk("port disable", {4'h0, port_disable}, 8'h00);
	endtask
	task automatic t_status;
		port_class[8:6] = 3'h4;
		for (int f = 0; f < 8; f++) begin
			fault_code[8:6] = 3'(f);
			rchk(2'h2, PPC_SEL_STATUS_ONE, {5'h04, (f > 4) ? 3'h0 : 3'(f)});
		end
		fault_code[8:6] = 3'h0;
		{func_done_evt[2], disc_fail_evt[2], wdog_active[2], func_state[8:6]} = 6'h3D;
		@(negedge ref_clk);
		{func_done_evt[2], disc_fail_evt[2]} = 2'h0;
		rchk(2'h2, PPC_SEL_STATUS_ONE, 8'hE0);
		rchk(2'h2, PPC_SEL_STATUS_TWO, 8'h15);
		i_ppc_host.wr(2'h2, PPC_SEL_CTRL_ONE, 8'h02);
		chk("function code", {4'h0, func_code[11:8]}, 8'h02);
		rchk(2'h2, PPC_SEL_STATUS_ONE, 8'h20);
	endtask
	// a frozen clock enable stretches the conversion without losing it
	task automatic t_freeze;
		adc_sample[59:45] = 15'h1234;
		i_ppc_host.wr(2'h3, PPC_SEL_CTRL_TWO, 8'h08);
		chk("conversion active", {4'h0, conv_active}, 8'h08);
		i_ppc_host.hold(40);
		rchk(2'h3, PPC_SEL_STATUS_TWO, 8'h08);
		repeat (34) @(negedge ref_clk);
		rchk(2'h3, PPC_SEL_DISC_LOW, 8'h34);
		rchk(2'h3, PPC_SEL_DISC_HIGH, 8'h92);
	endtask
	task automatic give_verdict;
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		for (int s = 0; s < 16; s++)
			rchk(2'h3, 4'(s), 8'h00);
		t_disc;
		t_abort;
		t_status;
		t_freeze;
		give_verdict;
	end
	initial begin
		#50us;
		bad_count++;
		give_verdict;
	end
endmodule
